// ---- verilog/splpm_pkg.sv ----
// Constants for the downstream split control and power management capability registers
package splpm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam logic [11:0] DOWN_SPLIT_CTRL_OFFSET = 12'h08c;
   localparam logic [11:0] PM_CAP_HDR_OFFSET = 12'h0a0;
   localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // downstream_split_control fields
   localparam int unsigned COMMIT_LIMIT_LSB = 16;
   localparam int unsigned COMMIT_LIMIT_MSB = 31;
   localparam int unsigned COMMIT_LIMIT_W = 16;
   localparam int unsigned CAPACITY_LSB = 0;
   localparam int unsigned CAPACITY_MSB = 15;
   localparam logic [15:0] COMPLETION_BUFFER_CAPACITY = 16'h0004;
   localparam logic [15:0] COMMIT_LIMIT_RESET = COMPLETION_BUFFER_CAPACITY;
   localparam logic [31:0] DOWN_SPLIT_CTRL_RESET = 32'h0004_0004;

   ////////////////////////////////////////////////////////////////////////////////
   // power_mgmt_capability_header fields
   localparam int unsigned WAKE_MASK_LSB = 27;
   localparam int unsigned WAKE_MASK_MSB = 31;
   localparam int unsigned WAKE_MASK_W = 5;
   localparam logic [4:0] WAKE_MASK_RESET = 5'h0f;
   localparam int unsigned SECOND_LP_FLAG_BIT = 26;
   localparam int unsigned FIRST_LP_FLAG_BIT = 25;
   localparam int unsigned AUX_DRAW_LSB = 22;
   localparam int unsigned AUX_DRAW_MSB = 24;
   localparam int unsigned SPECIAL_INIT_BIT = 21;
   localparam int unsigned RESERVED_BIT = 20;
   localparam int unsigned WAKE_CLOCK_BIT = 19;
   localparam int unsigned PM_REVISION_LSB = 16;
   localparam int unsigned PM_REVISION_MSB = 18;
   localparam int unsigned NEXT_LINK_LSB = 8;
   localparam int unsigned NEXT_LINK_MSB = 15;
   localparam int unsigned CAPABILITY_IDENTIFIER_LSB = 0;
   localparam int unsigned CAPABILITY_IDENTIFIER_MSB = 7;
   localparam logic [0:0] SECOND_LP_FLAG_VALUE = 1'h0;
   localparam logic [0:0] FIRST_LP_FLAG_VALUE = 1'h0;
   localparam logic [2:0] AUX_DRAW_VALUE = 3'h0;
   localparam logic [0:0] SPECIAL_INIT_VALUE = 1'h0;
   localparam logic [0:0] RESERVED_VALUE = 1'h0;
   localparam logic [0:0] WAKE_CLOCK_VALUE = 1'h0;
   localparam logic [2:0] PM_REVISION_VALUE = 3'h3;
   localparam logic [7:0] NEXT_LINK_VALUE = 8'hc0;
   localparam logic [7:0] CAPABILITY_IDENTIFIER_VALUE = 8'h01;
   localparam logic [31:0] PM_CAP_HDR_RESET = 32'h7803_c001;

endpackage

// ---- verilog/splpm_field_reg.sv ----
// Loadable field register with a constant reset value
`timescale 1ns/1ps
module splpm_field_reg
#(
   parameter int unsigned W = 16,
   parameter logic [W-1:0] RESET_VALUE = '0
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic loadEn,
   input wire logic [W-1:0] loadData,
   output logic [W-1:0] value
);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [W-1:0] value_q;
   logic [W-1:0] value_d;

   assign value_d = loadEn ? loadData : value_q;
   assign value = value_q;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         value_q <= RESET_VALUE;
      end
      else
      begin
         value_q <= value_d;
      end
   end

endmodule

// ---- verilog/splpm_regs.sv ----
// Downstream split control and power management capability header registers
`timescale 1ns/1ps

module splpm_regs
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic eepromWakeValid,
   input wire logic [4:0] eepromWakeMask,
   output logic [15:0] requestCommitLimit,
   output logic [4:0] wakeEventStateMask
);

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire hitSplitCtrl;
   wire hitPmCap;
   wire writeSplitCtrl;
   wire readSplitCtrl;
   wire readPmCap;
   wire writePmCap;

   assign hitSplitCtrl = (regAddr == splpm_pkg::DOWN_SPLIT_CTRL_OFFSET);
   assign hitPmCap = (regAddr == splpm_pkg::PM_CAP_HDR_OFFSET);
   assign writeSplitCtrl = regWrite & hitSplitCtrl;
   assign readSplitCtrl = regRead & hitSplitCtrl;
   assign readPmCap = regRead & hitPmCap;
   assign writePmCap = regWrite & hitPmCap;

   ////////////////////////////////////////////////////////////////////////////////
   // Commitment limit, loaded by software writes
   wire [15:0] commitLimitIn;
   logic [15:0] commitLimit;

   // Only the upper half is writable; capacity bits of the write are dropped
   assign commitLimitIn =
      regWrData[splpm_pkg::COMMIT_LIMIT_MSB:splpm_pkg::COMMIT_LIMIT_LSB];

   splpm_field_reg
   #(
      .W(16),
      .RESET_VALUE(splpm_pkg::COMMIT_LIMIT_RESET)
   )
   uCommitLimit
   (
      .clock(clock),
      .reset_n(reset_n),
      .loadEn(writeSplitCtrl),
      .loadData(commitLimitIn),
      .value(commitLimit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Wake-event state mask, loaded from the EEPROM loader
   logic [4:0] wakeMask;

   splpm_field_reg
   #(
      .W(5),
      .RESET_VALUE(splpm_pkg::WAKE_MASK_RESET)
   )
   uWakeMask
   (
      .clock(clock),
      .reset_n(reset_n),
      .loadEn(eepromWakeValid),
      .loadData(eepromWakeMask),
      .value(wakeMask)
   );

   assign requestCommitLimit = commitLimit;
   assign wakeEventStateMask = wakeMask;

   ////////////////////////////////////////////////////////////////////////////////
   // Read words
   wire [31:0] splitCtrlWord;
   wire [31:0] pmCapWord;
   wire [31:0] readWord;

   assign splitCtrlWord = {commitLimit, splpm_pkg::COMPLETION_BUFFER_CAPACITY};

   assign pmCapWord = {
      wakeMask,
      splpm_pkg::SECOND_LP_FLAG_VALUE,
      splpm_pkg::FIRST_LP_FLAG_VALUE,
      splpm_pkg::AUX_DRAW_VALUE,
      splpm_pkg::SPECIAL_INIT_VALUE,
      splpm_pkg::RESERVED_VALUE,
      splpm_pkg::WAKE_CLOCK_VALUE,
      splpm_pkg::PM_REVISION_VALUE,
      splpm_pkg::NEXT_LINK_VALUE,
      splpm_pkg::CAPABILITY_IDENTIFIER_VALUE
   };

   assign readWord = readSplitCtrl ? splitCtrlWord :
                     readPmCap ? pmCapWord :
                     splpm_pkg::UNMAPPED_READ_VALUE;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the strobe
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;

   assign rdData_d = regRead ? readWord : splpm_pkg::UNMAPPED_READ_VALUE;
   assign regRdData = rdData_q;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdData_q <= splpm_pkg::UNMAPPED_READ_VALUE;
      end
      else
      begin
         rdData_q <= rdData_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helper state for checks
   logic limitWritten_q;
   logic wakeLoaded_q;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         limitWritten_q <= 1'b0;
         wakeLoaded_q <= 1'b0;
      end
      else
      begin
         limitWritten_q <= limitWritten_q | writeSplitCtrl;
         wakeLoaded_q <= wakeLoaded_q | eepromWakeValid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_LIMIT_WRITE:
   assert property (@(posedge clock) disable iff (!reset_n)
      writeSplitCtrl |=> requestCommitLimit == $past(regWrData[31:16]))
   else
      $error("Commit limit did not take the written value");

   AST_LIMIT_READBACK:
   assert property (@(posedge clock) disable iff (!reset_n)
      (writeSplitCtrl ##1 readSplitCtrl) |=>
         regRdData[31:16] == $past(regWrData[31:16], 2))
   else
      $error("Commit limit read back differs from the last write");

   AST_LIMIT_RESET:
   assert property (@(posedge clock) disable iff (!reset_n)
      !limitWritten_q |-> requestCommitLimit == 16'h0004)
   else
      $error("Commit limit left its reset value without a write");

   AST_CAPACITY_FIXED:
   assert property (@(posedge clock) disable iff (!reset_n)
      readSplitCtrl |=> regRdData[15:0] == 16'h0004)
   else
      $error("Completion buffer capacity did not read 0x0004");

   AST_WAKE_LOAD:
   assert property (@(posedge clock) disable iff (!reset_n)
      (eepromWakeValid ##1 readPmCap) |=>
         regRdData[31:27] == $past(eepromWakeMask, 2))
   else
      $error("Wake mask read back differs from the loaded value");

   AST_WAKE_DEFAULT:
   assert property (@(posedge clock) disable iff (!reset_n)
      (!wakeLoaded_q && readPmCap) |=> regRdData[31:27] == 5'b01111)
   else
      $error("Wake mask default is not 01111");

   AST_LOW_POWER_FLAGS:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> regRdData[26:25] == 2'b00)
   else
      $error("Low-power state flags did not read zero");

   AST_AUX_DRAW:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> regRdData[24:22] == 3'b000)
   else
      $error("Auxiliary draw field did not read zero");

   AST_SPECIAL_INIT:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> !regRdData[21])
   else
      $error("Special initialization flag did not read zero");

   AST_RESERVED_BIT:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> !regRdData[20])
   else
      $error("Reserved bit did not read zero");

   AST_WAKE_CLOCK:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> !regRdData[19])
   else
      $error("Wake clock flag did not read zero");

   AST_PM_REVISION:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> regRdData[18:16] == 3'b011)
   else
      $error("Power management revision did not read 011");

   AST_NEXT_LINK:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> regRdData[15:8] == 8'hc0)
   else
      $error("Following capability link did not read 0xc0");

   AST_CAPABILITY_IDENTIFIER:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> regRdData[7:0] == 8'h01)
   else
      $error("Capability identifier did not read 0x01");

   AST_RO_WRITE_IGNORED:
   assert property (@(posedge clock) disable iff (!reset_n)
      (writePmCap && !eepromWakeValid) |=> $stable(wakeEventStateMask))
   else
      $error("Write to the capability header changed the wake mask");

   AST_READ_ONE_CYCLE:
   assert property (@(posedge clock) disable iff (!reset_n)
      !regRead |=> regRdData == 32'h0000_0000)
   else
      $error("Read data present without a read strobe");

   AST_LIMIT_HOLD:
   assert property (@(posedge clock) disable iff (!reset_n)
      !writeSplitCtrl |=> $stable(requestCommitLimit))
   else
      $error("Commit limit changed without a write");

   AST_LIMIT_READ_CURRENT:
   assert property (@(posedge clock) disable iff (!reset_n)
      readSplitCtrl |=> regRdData[31:16] == $past(requestCommitLimit))
   else
      $error("Commit limit read differs from the limit in use");

   AST_SPLIT_WORD_RESET:
   assert property (@(posedge clock) disable iff (!reset_n)
      (!limitWritten_q && readSplitCtrl) |=>
         regRdData == splpm_pkg::DOWN_SPLIT_CTRL_RESET)
   else
      $error("Split control word did not read its reset value");

   AST_WAKE_HOLD:
   assert property (@(posedge clock) disable iff (!reset_n)
      !eepromWakeValid |=> $stable(wakeEventStateMask))
   else
      $error("Wake mask changed without a load");

   AST_WAKE_FOLLOWS_LOAD:
   assert property (@(posedge clock) disable iff (!reset_n)
      eepromWakeValid |=> wakeEventStateMask == $past(eepromWakeMask))
   else
      $error("Wake mask did not take the loaded value");

   AST_WAKE_READ_CURRENT:
   assert property (@(posedge clock) disable iff (!reset_n)
      readPmCap |=> regRdData[31:27] == $past(wakeEventStateMask))
   else
      $error("Wake mask read differs from the mask in use");

   AST_PM_WORD_RESET:
   assert property (@(posedge clock) disable iff (!reset_n)
      (!wakeLoaded_q && readPmCap) |=>
         regRdData == splpm_pkg::PM_CAP_HDR_RESET)
   else
      $error("Capability header did not read its reset value");

   AST_RO_WRITE_LIMIT_KEPT:
   assert property (@(posedge clock) disable iff (!reset_n)
      (regWrite && !hitSplitCtrl) |=> $stable(requestCommitLimit))
   else
      $error("Write elsewhere changed the commit limit");

   AST_RO_WRITE_MASK_KEPT:
   assert property (@(posedge clock) disable iff (!reset_n)
      (regWrite && !eepromWakeValid) |=> $stable(wakeEventStateMask))
   else
      $error("Register write changed the wake mask");

   AST_UNMAPPED_READ:
   assert property (@(posedge clock) disable iff (!reset_n)
      (regRead && !hitSplitCtrl && !hitPmCap) |=>
         regRdData == splpm_pkg::UNMAPPED_READ_VALUE)
   else
      $error("Unmapped read returned data");

endmodule

// ---- sim/splpm_requester.sv ----
// Upstream requester model: configuration accesses and the EEPROM mask loader
`timescale 1ns/1ps
module splpm_requester
(
   input wire logic clock,
   output logic [11:0] regAddr,
   output logic [31:0] regWrData,
   output logic regWrite,
   output logic regRead,
   output logic eepromWakeValid,
   output logic [4:0] eepromWakeMask
);
   initial
   begin
      regAddr = 12'h000;
      regWrData = 32'h0000_0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      eepromWakeValid = 1'b0;
      eepromWakeMask = 5'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One cycle per call; strobes stay up so calls run back to back
   task automatic drive(input logic w, input logic r, input logic [11:0] a,
                        input logic [31:0] d, input logic l, input logic [4:0] m);
   begin
      logic [31:0] wrWord;
      wrWord = d;
      if (w && a == 12'h08c && d[31:16] < 16'h0004)
         wrWord = {16'h0004, d[15:0]};
      regWrite <= w;
      regRead <= r;
      regAddr <= a;
      regWrData <= wrWord;
      eepromWakeValid <= l;
      eepromWakeMask <= m;
      @(posedge clock);
   end
   endtask

   // Released lines show the inverse of the last value
   task automatic idle();
   begin
      drive(1'b0, 1'b0, ~regAddr, ~regWrData, 1'b0, ~eepromWakeMask);
   end
   endtask
endmodule

// ---- sim/split_limit_and_pm_capability_regs_test.sv ----
// Self-checking bench for the split control and power management header registers
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
$display("BAD at %0t got %h expected %h", $time, got, exp); end end
module split_limit_and_pm_capability_regs_test;
   logic clock;
   logic reset_n;
   logic [11:0] regAddr;
   logic [31:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [31:0] regRdData;
   logic eepromWakeValid;
   logic [4:0] eepromWakeMask;
   logic [15:0] requestCommitLimit;
   logic [4:0] wakeEventStateMask;
   int num_errors = 0;
   int checks_done = 0;
   int seed = 32'h42dfde0b;
   int r;
   logic [15:0] limModel;
   logic [4:0] maskModel;
   logic [32:0] rdQ[$];
   logic [32:0] rdNow;
   logic [11:0] addrTab[4] = '{12'h08c, 12'h0a0, 12'h088, 12'h0a4};

   splpm_regs dut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .eepromWakeValid(eepromWakeValid), .eepromWakeMask(eepromWakeMask),
      .requestCommitLimit(requestCommitLimit), .wakeEventStateMask(wakeEventStateMask));

   splpm_requester req (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .eepromWakeValid(eepromWakeValid),
      .eepromWakeMask(eepromWakeMask));

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Behavioural model, compared every cycle
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         limModel = 16'h0004;
         maskModel = 5'h0f;
         rdQ = {33'h0};
      end
      else
      begin
         rdNow = rdQ.pop_front();
         `CHK(regRdData, rdNow[31:0])
         if (rdNow[32])
         begin
            `CHK(regRdData[26:25], 2'h0)
            `CHK(regRdData[24:22], 3'h0)
            `CHK(regRdData[21], 1'h0)
            `CHK(regRdData[20], 1'h0)
            `CHK(regRdData[19], 1'h0)
            `CHK(regRdData[18:16], 3'h3)
            `CHK(regRdData[15:8], 8'hc0)
            `CHK(regRdData[7:0], 8'h01)
         end
         if (rdNow[31:0] !== 32'h0 && !rdNow[32])
            `CHK(regRdData[15:0], 16'h0004)
         `CHK(requestCommitLimit, limModel)
         `CHK(wakeEventStateMask, maskModel)
         if (!regRead)
            rdQ.push_back(33'h0);
         else if (regAddr == 12'h08c)
            rdQ.push_back({1'b0, limModel, 16'h0004});
         else if (regAddr == 12'h0a0)
            rdQ.push_back({1'b1, maskModel, 27'h003c001});
         else
            rdQ.push_back(33'h0);
         if (regWrite && regAddr == 12'h08c)
            limModel = regWrData[31:16];
         if (eepromWakeValid)
            maskModel = eepromWakeMask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict
   task automatic end_of_test();
   begin
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask

   initial
   begin
      repeat (100000) @(posedge clock);
      num_errors++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stimulus
   initial
   begin
      reset_n = 1'b0;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      // Reset values, back to back reads
      req.drive(1'b0, 1'b1, 12'h08c, 32'h0, 1'b0, 5'h00);
      req.drive(1'b0, 1'b1, 12'h0a0, 32'h0, 1'b0, 5'h00);
      // Read-only, unmapped and commit limit writes, then reads
      req.drive(1'b1, 1'b0, 12'h0a0, 32'hffff_ffff, 1'b0, 5'h00);
      req.drive(1'b1, 1'b0, 12'h0a4, 32'hffff_ffff, 1'b0, 5'h00);
      req.drive(1'b1, 1'b0, 12'h08c, 32'hffff_1234, 1'b0, 5'h00);
      req.drive(1'b0, 1'b1, 12'h08c, 32'h0, 1'b0, 5'h00);
      req.drive(1'b0, 1'b1, 12'h088, 32'h0, 1'b1, 5'h1f);
      req.drive(1'b0, 1'b1, 12'h0a0, 32'h0, 1'b1, 5'h00);
      req.drive(1'b1, 1'b0, 12'h08c, 32'h0004_ffff, 1'b0, 5'h00);
      req.drive(1'b0, 1'b1, 12'h08c, 32'h0, 1'b0, 5'h00);
      req.drive(1'b0, 1'b1, 12'h0a0, 32'h0, 1'b0, 5'h00);
      // Random traffic over mapped and unmapped places
      repeat (400)
      begin
         r = $random(seed);
         if (r[3:2] == 2'h0)
            req.idle();
         else
            req.drive(r[4], !r[4], addrTab[r[6:5]], $random(seed), r[7], r[12:8]);
      end
      // Mid-run reset reloads the limit
      req.idle();
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      req.drive(1'b0, 1'b1, 12'h08c, 32'h0, 1'b0, 5'h00);
      req.drive(1'b0, 1'b1, 12'h0a0, 32'h0, 1'b0, 5'h00);
      req.idle();
      repeat (3) @(posedge clock);
      end_of_test();
   end
endmodule
